// [hdl/smbus_slave_pkg.sv]
// Constants, types and timing for the two-wire RAM/EEPROM slave port
package smbus_slave_pkg;

    // Bus addressing and command codes
    localparam logic [4:0]  SLAVE_ADDR_UPPER = 5'h0b;
    localparam logic [7:0]  RAM_TOP          = 8'hdf;
    localparam logic [7:0]  NV_HIGH_MIN      = 8'hf8;
    localparam logic [7:0]  NV_HIGH_MAX      = 8'hfb;
    localparam logic [5:0]  NV_HIGH_TAG      = 6'h3e;
    localparam logic [7:0]  CMD_BLOCK_WRITE  = 8'hfc;
    localparam logic [7:0]  CMD_BLOCK_READ   = 8'hfd;
    localparam logic [7:0]  CMD_PAGE_ERASE   = 8'hfe;
    localparam logic [7:0]  BLOCK_COUNT      = 8'h20;
    localparam logic [7:0]  BLANK_BYTE       = 8'hff;
    localparam logic [5:0]  BLOCK_LAST_IDX   = 6'h20;
    localparam logic [5:0]  IDX_MAX          = 6'h3f;

    // Update-configuration register
    localparam logic [7:0]  CFG_UPDATE_ADDR  = 8'h90;
    localparam logic [7:0]  CFG_RESET        = 8'h00;
    localparam int          CFG_LATCH_BIT    = 1;
    localparam int          CFG_ERASE_BIT    = 2;

    // Link recovery
    localparam logic [4:0]  FLUSH_PULSES     = 5'h10;

    // Timing, figures in their own units
    localparam int unsigned CLK_MHZ          = 125;
    localparam int unsigned CLK_KHZ          = 125000;
    localparam int unsigned PROG_TIME_US     = 250;
    localparam int unsigned ERASE_TIME_MS    = 20;
    localparam int unsigned TIMEOUT_MS       = 30;
    localparam int unsigned PROG_CYCLES_DEF    = PROG_TIME_US * CLK_MHZ;
    localparam int unsigned ERASE_CYCLES_DEF   = ERASE_TIME_MS * CLK_KHZ;
    localparam int unsigned TIMEOUT_CYCLES_DEF = TIMEOUT_MS * CLK_KHZ;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_ADDR     = 3'b001,
        ST_ACK_WAIT = 3'b010,
        ST_ACK_HOLD = 3'b011,
        ST_ACK_END  = 3'b100,
        ST_WRITE    = 3'b101,
        ST_READ     = 3'b110,
        ST_RD_ACK   = 3'b111
    } link_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       we;
    } ram_req_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        prog;
        logic        erase;
    } nv_req_t;

endpackage

// [hdl/link_bit_capture.sv]
// SCL-domain capture of each data bit with a toggle for the crossing
module link_bit_capture
    import smbus_slave_pkg::*;
(
    input  wire logic scl_clk,
    input  wire logic reset_n,
    input  wire logic sda_in,
    output logic      bit_val,
    output logic      bit_tgl
);

    logic next_bit_val;
    logic next_bit_tgl;

    // Held until the next SCL rise, far longer than the crossing takes
    always_comb begin
        next_bit_val = sda_in;
        next_bit_tgl = ~bit_tgl;
    end

    always_ff @(posedge scl_clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_val <= 1'b1;
            bit_tgl <= 1'b0;
        end else begin
            bit_val <= next_bit_val;
            bit_tgl <= next_bit_tgl;
        end
    end

endmodule

// [hdl/smbus_ram_eeprom_slave.sv]
// Two-wire slave port giving a bus master access to user RAM and EEPROM
// Operation
// - SDA falling while SCL high starts a frame; shift in next eight bits.
// - First byte is 7-bit address MSB first, then direction: 0 write, 1 read.
// - On address match, drive SDA low before and through the ninth pulse.
// - Each byte is nine pulses: eight data bits and one acknowledge.
// - SDA changes only while SCL low; SDA rising while SCL high is stop. The code's flush releases SDA just after an SCL rise.
// - First byte after address in a write is the command byte.
// - SCL held low about 30 ms times out and abandons the transaction.
// - Up to 16 flush pulses release an SDA line held low.
// - RAM decodes 0x00 to 0xDF, EEPROM decodes 0xF800 to 0xFBFF.
// - EEPROM bytes program only when blank; erasure works on 32-byte pages.
// - Page erase happens only when bit 2 of register 0x90 is set.
// - Send-byte with a RAM address loads that address into the pointer.
// - Command 0xFE erases the page selected by the earlier pointer setup.
// - Erase starts at the command byte, lasts 20 ms, accesses are refused.
// - Write-byte to a RAM address stores the one data byte there.
// - Write-byte with command 0xF8 to 0xFB sets the 16-bit EEPROM pointer.
// - Erase selects the page by pointer bits 9 to 5: the low byte's upper three bits and two from the high byte.
// - Write-word with 0xF8 to 0xFB: low address byte, then value to program.
// - Slave address is 01011 then the two sampled address-select pins.
// - Command 0xFC is block write, 0xFD block read, both from the pointer.
// - Block read sends count 0x20, then exactly 32 data bytes.
// - Programming takes 250 us; SCL is held low until data can be taken.
module smbus_ram_eeprom_slave
    import smbus_slave_pkg::*;
#(
    parameter int unsigned PROG_CYCLES    = PROG_CYCLES_DEF,
    parameter int unsigned ERASE_CYCLES   = ERASE_CYCLES_DEF,
    parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYCLES_DEF
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       scl_clk,
    output logic            scl_out,
    output logic            scl_oe,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       addr_select_high,
    input  wire logic       addr_select_low,
    output ram_req_t        ram_req,
    input  wire logic [7:0] ram_rdata,
    output nv_req_t         nv_req,
    input  wire logic [7:0] nv_rdata,
    output logic [7:0]      config_update_control,
    output logic            latch_update,
    output logic            nv_busy
);

    function automatic logic in_nv(input logic [15:0] p);
        in_nv = (p[15:10] == NV_HIGH_TAG);
    endfunction

    function automatic logic [7:0] read_at(input logic [15:0] p, input logic [7:0] ramd,
                                           input logic [7:0] nvd, input logic [7:0] cfgv);
        if (p[15:8] == 8'h00 && p[7:0] <= RAM_TOP) begin
            read_at = (p[7:0] == CFG_UPDATE_ADDR) ? cfgv : ramd;
        end else if (in_nv(p)) begin
            read_at = nvd;
        end else begin
            read_at = BLANK_BYTE;
        end
    endfunction

    // Pin synchronisers and the bit-event crossing
    logic       scl_s1, scl_s2, scl_d;
    logic       sda_s1, sda_s2, sda_d;
    logic [1:0] sel_s1, sel_s2;
    logic       tgl_s1, tgl_s2, tgl_d;
    logic       link_bit, link_tgl;

    link_bit_capture u_capture (
        .scl_clk (scl_clk),
        .reset_n (reset_n),
        .sda_in  (sda_in),
        .bit_val (link_bit),
        .bit_tgl (link_tgl)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d  <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d  <= 1'b1;
            sel_s1 <= 2'h0;
            sel_s2 <= 2'h0;
            tgl_s1 <= 1'b0;
            tgl_s2 <= 1'b0;
            tgl_d  <= 1'b0;
        end else begin
            scl_s1 <= scl_clk;
            scl_s2 <= scl_s1;
            scl_d  <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_d  <= sda_s2;
            sel_s1 <= {addr_select_high, addr_select_low};
            sel_s2 <= sel_s1;
            tgl_s1 <= link_tgl;
            tgl_s2 <= tgl_s1;
            tgl_d  <= tgl_s2;
        end
    end

    logic start_seen, stop_seen, scl_fall, bit_event;
    assign start_seen = scl_s2 && scl_d && sda_d && !sda_s2;
    assign stop_seen  = scl_s2 && scl_d && !sda_d && sda_s2;
    assign scl_fall   = scl_d && !scl_s2;
    assign bit_event  = tgl_s2 ^ tgl_d;

    // Protocol state
    link_state_t state, next_state;
    logic [3:0]  bit_cnt, next_bit_cnt;
    logic [7:0]  shreg, next_shreg;
    logic [5:0]  idx, next_idx;
    logic [7:0]  cmd, next_cmd;
    logic [15:0] ptr, next_ptr;
    logic [7:0]  blk_cnt, next_blk_cnt;
    logic [7:0]  wbyte, next_wbyte;
    logic [7:0]  cfg, next_cfg;
    logic        ram_we_q, next_ram_we;
    logic        prog_q, next_prog;
    logic        erase_q, next_erase;
    logic        latch_q, next_latch;
    logic        blk_rd, next_blk_rd;
    logic        is_read, next_is_read;
    logic        sda_oe_q, next_sda_oe;
    logic        scl_oe_q, next_scl_oe;
    logic        erasing, next_erasing;
    logic [31:0] busy_cnt, next_busy_cnt;
    logic [31:0] to_cnt, next_to_cnt;
    logic [4:0]  flush_cnt, next_flush_cnt;

    logic [7:0] rx_byte;
    logic       do_store;
    logic [7:0] tx_byte;
    assign rx_byte = {shreg[6:0], link_bit};

    always_comb begin
        next_state     = state;
        next_bit_cnt   = bit_cnt;
        next_shreg     = shreg;
        next_idx       = idx;
        next_cmd       = cmd;
        next_ptr       = ptr;
        next_blk_cnt   = blk_cnt;
        next_wbyte     = wbyte;
        next_cfg       = cfg;
        next_ram_we    = 1'b0;
        next_prog      = 1'b0;
        next_erase     = 1'b0;
        next_latch     = 1'b0;
        next_blk_rd    = blk_rd;
        next_is_read   = is_read;
        next_sda_oe    = sda_oe_q;
        next_erasing   = erasing;
        next_busy_cnt  = busy_cnt;
        next_to_cnt    = 32'h0;
        next_flush_cnt = sda_oe_q ? flush_cnt : 5'h0;
        do_store       = 1'b0;
        tx_byte        = BLANK_BYTE;

        // Nonvolatile timer; release after it runs out needs no reset
        if (busy_cnt != 32'h0) begin
            next_busy_cnt = busy_cnt - 32'h1;
        end else begin
            next_erasing = 1'b0;
        end

        // Block read answer: count byte first, then 32 bytes, then blanks
        if (blk_rd && idx == 6'h00) begin
            tx_byte = BLOCK_COUNT;
        end else if (!blk_rd || idx <= BLOCK_LAST_IDX) begin
            tx_byte = read_at(ptr, ram_rdata, nv_rdata, cfg);
        end

        case (state)
            ST_IDLE: begin
                next_sda_oe = 1'b0;
            end
            ST_ADDR, ST_WRITE: begin
                if (bit_event) begin
                    next_shreg   = rx_byte;
                    next_bit_cnt = bit_cnt + 4'h1;
                    if (bit_cnt == 4'h7) begin
                        next_bit_cnt = 4'h0;
                        next_state   = ST_ACK_WAIT;
                        if (state == ST_ADDR) begin
                            next_idx     = 6'h00;
                            next_is_read = rx_byte[0];
                            // Busy erase refuses every access
                            if (rx_byte[7:1] != {SLAVE_ADDR_UPPER, sel_s2} || erasing) begin
                                next_state = ST_IDLE;
                            end
                        end else begin
                            next_idx = (idx == IDX_MAX) ? idx : idx + 6'h1;
                            if (idx == 6'h00) begin
                                next_cmd    = rx_byte;
                                next_blk_rd = (rx_byte == CMD_BLOCK_READ);
                                if (rx_byte <= RAM_TOP) begin
                                    next_ptr = {8'h00, rx_byte};
                                // A pointer outside the array erases nothing
                                end else if (rx_byte == CMD_PAGE_ERASE && cfg[CFG_ERASE_BIT]
                                             && in_nv(ptr)) begin
                                    next_erase    = 1'b1;
                                    next_erasing  = 1'b1;
                                    next_busy_cnt = ERASE_CYCLES;
                                end
                            end else if (cmd <= RAM_TOP) begin
                                do_store = (idx == 6'h01);
                            end else if (cmd >= NV_HIGH_MIN && cmd <= NV_HIGH_MAX) begin
                                if (idx == 6'h01) begin
                                    next_ptr = {cmd, rx_byte};
                                end else begin
                                    do_store = (idx == 6'h02);
                                end
                            end else if (cmd == CMD_BLOCK_WRITE) begin
                                if (idx == 6'h01) begin
                                    next_blk_cnt = rx_byte;
                                end else if ({2'h0, idx} - 8'h02 < blk_cnt) begin
                                    do_store = 1'b1;
                                end
                            end
                        end
                    end
                end
            end
            ST_ACK_WAIT: begin
                if (scl_fall) begin
                    next_sda_oe = 1'b1;
                    next_state  = ST_ACK_HOLD;
                end
            end
            ST_ACK_HOLD: begin
                if (bit_event) begin
                    next_state = ST_ACK_END;
                end
            end
            ST_ACK_END: begin
                if (scl_fall) begin
                    next_bit_cnt = 4'h0;
                    if (is_read) begin
                        next_shreg  = tx_byte;
                        next_sda_oe = ~tx_byte[7];
                        next_state  = ST_READ;
                        if (!(blk_rd && idx == 6'h00)) begin
                            next_ptr = ptr + 16'h1;
                        end
                        next_idx = (idx == IDX_MAX) ? idx : idx + 6'h1;
                    end else begin
                        next_sda_oe = 1'b0;
                        next_state  = ST_WRITE;
                    end
                end
            end
            ST_READ: begin
                if (bit_event) begin
                    next_shreg   = {shreg[6:0], 1'b1};
                    next_bit_cnt = bit_cnt + 4'h1;
                    if (bit_cnt == 4'h7) begin
                        next_state = ST_RD_ACK;
                    end
                end else if (scl_fall) begin
                    // Data moves only while SCL is low
                    next_sda_oe = ~shreg[7];
                end
            end
            ST_RD_ACK: begin
                if (scl_fall) begin
                    next_sda_oe = 1'b0;
                end else if (bit_event) begin
                    next_state = link_bit ? ST_IDLE : ST_ACK_END;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase

        if (do_store) begin
            next_wbyte = rx_byte;
            next_ptr   = ptr + 16'h1;
            if (in_nv(ptr)) begin
                if (nv_rdata == BLANK_BYTE) begin
                    next_prog     = 1'b1;
                    next_busy_cnt = PROG_CYCLES;
                end
            end else if (ptr[15:8] == 8'h00 && ptr[7:0] <= RAM_TOP) begin
                next_ram_we = 1'b1;
                if (ptr[7:0] == CFG_UPDATE_ADDR) begin
                    // Latch bit is a command, it never stays set
                    next_cfg   = rx_byte & ~(8'h01 << CFG_LATCH_BIT);
                    next_latch = rx_byte[CFG_LATCH_BIT];
                end
            end
        end

        // Stuck SCL low: abandon so the master retries
        if (state != ST_IDLE && !scl_s2 && !scl_oe_q) begin
            next_to_cnt = to_cnt + 32'h1;
            if (to_cnt >= TIMEOUT_CYCLES - 32'h1) begin
                next_state  = ST_IDLE;
                next_sda_oe = 1'b0;
                next_to_cnt = 32'h0;
            end
        end

        // Clock flush frees a falsely held SDA
        if (sda_oe_q && bit_event) begin
            next_flush_cnt = flush_cnt + 5'h1;
            if (flush_cnt == FLUSH_PULSES - 5'h1) begin
                next_state  = ST_IDLE;
                next_sda_oe = 1'b0;
            end
        end

        // Start and stop override any byte in flight
        if (start_seen) begin
            next_state   = ST_ADDR;
            next_bit_cnt = 4'h0;
            next_sda_oe  = 1'b0;
        end else if (stop_seen) begin
            next_state  = ST_IDLE;
            next_sda_oe = 1'b0;
        end

        // Stretch only from an SCL low onward, never cutting a high phase short
        next_scl_oe = (busy_cnt > 32'h1) && !erasing && (scl_oe_q || scl_fall)
                      && (next_state != ST_IDLE);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state     <= ST_IDLE;
            bit_cnt   <= 4'h0;
            shreg     <= 8'h00;
            idx       <= 6'h00;
            cmd       <= 8'h00;
            ptr       <= 16'h0000;
            blk_cnt   <= 8'h00;
            wbyte     <= 8'h00;
            cfg       <= CFG_RESET;
            ram_we_q  <= 1'b0;
            prog_q    <= 1'b0;
            erase_q   <= 1'b0;
            latch_q   <= 1'b0;
            blk_rd    <= 1'b0;
            is_read   <= 1'b0;
            sda_oe_q  <= 1'b0;
            scl_oe_q  <= 1'b0;
            erasing   <= 1'b0;
            busy_cnt  <= 32'h0;
            to_cnt    <= 32'h0;
            flush_cnt <= 5'h0;
        end else begin
            state     <= next_state;
            bit_cnt   <= next_bit_cnt;
            shreg     <= next_shreg;
            idx       <= next_idx;
            cmd       <= next_cmd;
            ptr       <= next_ptr;
            blk_cnt   <= next_blk_cnt;
            wbyte     <= next_wbyte;
            cfg       <= next_cfg;
            ram_we_q  <= next_ram_we;
            prog_q    <= next_prog;
            erase_q   <= next_erase;
            latch_q   <= next_latch;
            blk_rd    <= next_blk_rd;
            is_read   <= next_is_read;
            sda_oe_q  <= next_sda_oe;
            scl_oe_q  <= next_scl_oe;
            erasing   <= next_erasing;
            busy_cnt  <= next_busy_cnt;
            to_cnt    <= next_to_cnt;
            flush_cnt <= next_flush_cnt;
        end
    end

    // Writes land one cycle after the pointer has already advanced
    assign ram_req = '{addr: ram_we_q ? ptr[7:0] - 8'h01 : ptr[7:0], wdata: wbyte, we: ram_we_q};
    assign nv_req  = '{addr: erase_q ? {ptr[15:5], 5'h00} : (prog_q ? ptr - 16'h1 : ptr),
                       wdata: wbyte, prog: prog_q, erase: erase_q};
    assign config_update_control = cfg;
    assign latch_update = latch_q;
    assign nv_busy      = (busy_cnt != 32'h0);
    assign sda_out      = 1'b0;
    assign sda_oe       = sda_oe_q;
    assign scl_out      = 1'b0;
    assign scl_oe       = scl_oe_q;

endmodule

// [tb/smbus_slave_sva.sv]
// Checker for the two-wire RAM/EEPROM slave port
module smbus_slave_sva
    import smbus_slave_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       scl_out,
    input  wire logic       scl_oe,
    input  wire logic       sda_out,
    input  ram_req_t        ram_req,
    input  nv_req_t         nv_req,
    input  wire logic [7:0] nv_rdata,
    input  wire logic [7:0] config_update_control,
    input  wire logic       nv_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    open_drain_a: assert property (!scl_out && !sda_out) else $error("line driven high");
    ram_strobe_a: assert property (ram_req.we |=> !ram_req.we) else $error("ram strobe long");
    prog_blank_a: assert property (nv_req.prog |-> nv_rdata == BLANK_BYTE) else $error("program over data");
    erase_gate_a: assert property (nv_req.erase |-> config_update_control[2]) else $error("erase not enabled");
    page_base_a: assert property (nv_req.erase |-> nv_req.addr[4:0] == 5'h00) else $error("erase not page");
    nv_range_a: assert property ((nv_req.erase || nv_req.prog) |-> nv_req.addr[15:10] == 6'h3e)
        else $error("nv address out of range");
    busy_start_a: assert property ((nv_req.erase || nv_req.prog) |=> nv_busy [*2]) else $error("busy missing");
    busy_end_a: assert property ($rose(nv_busy) |-> ##[1:1000] !nv_busy) else $error("busy stuck");
    stretch_busy_a: assert property (scl_oe |-> nv_busy || $past(nv_busy)) else $error("stray stretch");
    cover property (nv_req.erase);
    cover property (nv_req.prog);
    cover property (ram_req.we);
endmodule

bind smbus_ram_eeprom_slave smbus_slave_sva chk (.clk, .reset_n, .scl_out, .scl_oe, .sda_out, .ram_req, .nv_req,
    .nv_rdata, .config_update_control, .nv_busy);

// [tb/smbus_master_model.sv]
// Behavioural bus master driving the open-drain link lines
module smbus_master_model (
    input  wire logic scl_line,
    input  wire logic sda_line,
    output logic      scl_low,
    output logic      sda_low,
    output logic      hung
);
    timeunit 1ns;
    timeprecision 1ps;
    // Two 48 ns link periods a phase: synchronisers need phases above 40 ns
    localparam int PH = 96;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        hung = 1'b0;
    end
    task automatic bit_xfer(input logic b, output logic s);
        int n;
        #(PH/2);
        sda_low = !b;
        #(PH/2);
        scl_low = 1'b0;
        n = 0;
        while (!scl_line && n < 500) begin
            #8;
            n++;
        end
        if (n >= 500) hung = 1'b1;
        #(PH/2);
        s = sda_line;
        #(PH/2);
        scl_low = 1'b1;
    endtask
    task automatic start();
        sda_low = 1'b0;
        #PH;
        scl_low = 1'b0;
        #PH;
        sda_low = 1'b1;
        #PH;
        scl_low = 1'b1;
    endtask
    task automatic stop();
        #(PH/2);
        sda_low = 1'b1;
        #PH;
        scl_low = 1'b0;
        #PH;
        sda_low = 1'b0;
        #PH;
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_xfer(d[i], s);
        bit_xfer(1'b1, s);
        ack = !s;
    endtask
    task automatic get_byte(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
        bit_xfer(!more, s);
    endtask
endmodule

// [tb/tb.sv]
// Self-checking bench for the RAM/EEPROM slave port
module tb;
    import smbus_slave_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ADDR_W = {SLAVE_ADDR_UPPER, 2'b10, 1'b0};
    logic clk = 1'b0, reset_n, sel_hi, sel_lo, scl_oe, sda_oe, scl_out, sda_out, busy, scl_low, sda_low, hung;
    logic [7:0] ram_rdata, nv_rdata, cfg;
    logic [7:0] ram_mem [256];
    logic [7:0] nv_mem [1024];
    ram_req_t ram_req, ram_seen;
    nv_req_t nv_req, nv_seen;
    logic latch;
    int fails = 0, check_count = 0, prog_cnt = 0, erase_cnt = 0, latch_cnt = 0, stretch_cnt = 0;
    wire scl = !(scl_low || scl_oe);
    wire sda = !(sda_low || sda_oe);
    always #4 clk = !clk;
    assign ram_rdata = ram_mem[ram_req.addr];
    assign nv_rdata = nv_mem[nv_req.addr[9:0]];
    smbus_ram_eeprom_slave #(.PROG_CYCLES(40), .ERASE_CYCLES(600), .TIMEOUT_CYCLES(2000)) dut (
        .clk(clk), .reset_n(reset_n), .scl_clk(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_high(sel_hi), .addr_select_low(sel_lo),
        .ram_req(ram_req), .ram_rdata(ram_rdata), .nv_req(nv_req), .nv_rdata(nv_rdata),
        .config_update_control(cfg), .latch_update(latch), .nv_busy(busy));
    smbus_master_model m (.scl_line(scl), .sda_line(sda), .scl_low(scl_low), .sda_low(sda_low), .hung(hung));
    // Core storage behind the port
    always @(posedge clk) begin
        if (latch) latch_cnt <= latch_cnt + 1;
        if (scl_oe) stretch_cnt <= stretch_cnt + 1;
        if (ram_req.we) begin
            ram_mem[ram_req.addr] <= ram_req.wdata;
            ram_seen <= ram_req;
        end
        if (nv_req.prog) begin
            nv_mem[nv_req.addr[9:0]] <= nv_req.wdata;
            prog_cnt <= prog_cnt + 1;
            nv_seen <= nv_req;
        end
        if (nv_req.erase) begin
            for (int i = 0; i < 32; i++) nv_mem[{nv_req.addr[9:5], 5'(i)}] <= BLANK_BYTE;
            erase_cnt <= erase_cnt + 1;
            nv_seen <= nv_req;
        end
    end
    task automatic give_verdict();
        if (fails == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        check_count++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask
    task automatic xfer(input logic [7:0] b0, b1, b2, input int n, output logic ok);
        logic ack;
        logic [7:0] b [3];
        b = '{b0, b1, b2};
        m.start();
        m.put_byte(ADDR_W, ok);
        for (int i = 0; i < n; i++) begin
            m.put_byte(b[i], ack);
            ok = ok && ack;
        end
        m.stop();
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 2000) begin
            fails++;
            give_verdict();
        end
    endtask
    task automatic sc_ram();
        logic ok;
        logic [7:0] d;
        xfer(8'h10, 8'hab, 8'h00, 2, ok);
        chk("ram write ack", 1'b1, ok);
        chk("ram write", 16'h10ab, {ram_seen.addr, ram_seen.wdata});
        xfer(8'h10, 8'h00, 8'h00, 1, ok);
        m.start();
        m.put_byte(ADDR_W | 8'h01, ok);
        m.get_byte(1'b0, d);
        m.stop();
        chk("ram read", 8'hab, d);
    endtask
    task automatic sc_addr();
        logic ok;
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            {sel_hi, sel_lo} <= 2'(s);
            repeat (4) @(posedge clk);
            m.start();
            m.put_byte({SLAVE_ADDR_UPPER, 2'(s), 1'b0}, ok);
            m.stop();
            chk("own address", 1'b1, ok);
            m.start();
            m.put_byte({SLAVE_ADDR_UPPER, 2'(s + 1), 1'b0}, ok);
            m.stop();
            chk("other address", 1'b0, ok);
        end
        @(posedge clk);
        {sel_hi, sel_lo} <= 2'b10;
    endtask
    task automatic sc_program();
        logic ok;
        xfer(8'hf9, 8'h30, 8'h5a, 3, ok);
        wait_idle();
        chk("program", 24'hf9305a, {nv_seen.addr, nv_seen.wdata});
        chk("stretch", 1'b1, stretch_cnt > 0);
        xfer(8'hf9, 8'h30, 8'h11, 3, ok);
        wait_idle();
        chk("no reprogram", 1, prog_cnt);
    endtask
    task automatic sc_erase();
        logic ok;
        xfer(8'hf9, 8'h37, 8'h00, 2, ok);
        xfer(CMD_PAGE_ERASE, 8'h00, 8'h00, 1, ok);
        chk("erase gated", 0, erase_cnt);
        xfer(CFG_UPDATE_ADDR, 8'h06, 8'h00, 2, ok);
        chk("config", 8'h04, cfg);
        chk("latch pulse", 1, latch_cnt);
        xfer(8'hf9, 8'h37, 8'h00, 2, ok);
        xfer(CMD_PAGE_ERASE, 8'h00, 8'h00, 1, ok);
        xfer(8'h00, 8'h00, 8'h00, 0, ok);
        chk("busy refuse", 1'b0, ok);
        chk("erase page", 16'hf920, nv_seen.addr);
        wait_idle();
        xfer(8'h00, 8'h00, 8'h00, 0, ok);
        chk("answer again", 1'b1, ok);
    endtask
    task automatic sc_block();
        logic ok;
        logic [7:0] d;
        xfer(8'hf9, 8'h20, 8'h00, 2, ok);
        xfer(CMD_BLOCK_READ, 8'h00, 8'h00, 1, ok);
        m.start();
        m.put_byte(ADDR_W | 8'h01, ok);
        m.get_byte(1'b1, d);
        chk("block count", BLOCK_COUNT, d);
        for (int i = 0; i < 32; i++) begin
            m.get_byte(i < 31, d);
            chk("block data", BLANK_BYTE, d);
        end
        m.stop();
    endtask
    task automatic sc_timeout();
        logic ok, ack;
        m.start();
        m.put_byte(ADDR_W, ok);
        repeat (2100) @(posedge clk);
        m.put_byte(8'h10, ack);
        m.stop();
        chk("timeout nack", 1'b0, ack);
        xfer(8'h10, 8'h00, 8'h00, 1, ok);
        chk("answer after timeout", 1'b1, ok);
    endtask
    always @(posedge hung) begin
        fails++;
        give_verdict();
    end
    initial begin
        reset_n = 1'b0;
        {sel_hi, sel_lo} = 2'b10;
        for (int i = 0; i < 256; i++) ram_mem[i] = 8'h00;
        for (int i = 0; i < 1024; i++) nv_mem[i] = BLANK_BYTE;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        sc_ram();
        sc_addr();
        sc_program();
        sc_erase();
        sc_block();
        sc_timeout();
        give_verdict();
    end
endmodule
